// ===== hdl/nv_host_ctrl.sv
`timescale 1ns/10ps
`include "nv_host_cfg.svh"

// host that reads and writes the nvsram and runs store, recall and busy-line requests
module nv_host_ctrl
  import nv_host_pkg::*;
#(
  parameter int unsigned COPY_CYC   = `NV_CEIL_CYC(`NV_T_COPY_NS),
  parameter int unsigned RECALL_CYC = `NV_CEIL_CYC(`NV_T_RECALL_NS),
  parameter int unsigned REQ_CYC    = `NV_CEIL_CYC(`NV_T_REQ_MIN_NS) + 1,
  parameter int unsigned DELAY_CYC  = `NV_CEIL_CYC(`NV_T_REQ_DELAY_NS)
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             cmd_valid,
  input  wire nv_host_pkg::op_t cmd_op,
  input  wire logic [14:0]      cmd_addr,
  input  wire logic [7:0]       cmd_wdata,
  output logic                  cmd_ready,
  output logic                  rsp_valid,
  output logic [7:0]            rsp_rdata,
  output logic                  nv_busy,
  output logic [14:0]           address_pins,
  input  wire logic [7:0]       data_pins_in,
  output logic [7:0]            data_pins_out,
  output logic                  data_pins_oe,
  output logic                  chip_en_n,
  output logic                  write_en_n,
  output logic                  out_en_n,
  input  wire logic             store_busy_line_n_in,
  output logic                  store_busy_line_n_out,
  output logic                  store_busy_line_n_oe
);
  import nv_host_pkg::*;

  state_t      state;
  op_t         op;
  logic [14:0] addr;
  logic [7:0]  wdata;
  logic [2:0]  step;
  logic [31:0] cnt;
  logic        start;
  logic        done;
  logic        line_a;
  logic        line_s;
  logic        next_ready;

  // busy line comes from outside: two flops before anything looks at it
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      line_a <= 1'b1;
      line_s <= 1'b1;
    end
    else
    begin
      line_a <= store_busy_line_n_in;
      line_s <= line_a;
    end

  nv_pin_cycle u_cycle (
    .core_clk      (core_clk),
    .rstn          (rstn),
    .start         (start),
    .is_write      (op == OP_WRITE),
    .quiet         (state == ST_SEQ),
    .addr          (state == ST_SEQ ? seq_addr(step, op == OP_RECALL) : addr),
    .wdata         (wdata),
    .done          (done),
    .rdata         (rsp_rdata),
    .address_pins  (address_pins),
    .data_pins_in  (data_pins_in),
    .data_pins_out (data_pins_out),
    .data_pins_oe  (data_pins_oe),
    .chip_en_n     (chip_en_n),
    .write_en_n    (write_en_n),
    .out_en_n      (out_en_n)
  );

  // new work only once the line is seen high, so a store by any party drains first
  assign next_ready = (state == ST_IDLE) && !(cmd_valid && cmd_ready) && line_s;

  // main sequencer
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      state <= ST_IDLE;
      op    <= OP_READ;
      addr  <= 15'h0000;
      wdata <= 8'h00;
      step  <= 3'h0;
      cnt   <= 32'h0;
      start <= 1'b0;
    end
    else
    begin
      start <= 1'b0;
      cnt   <= cnt + 32'h1;
      unique case (state)
        ST_IDLE:
          if (cmd_valid && cmd_ready)
          begin
            op    <= cmd_op;
            addr  <= cmd_addr;
            wdata <= cmd_wdata;
            step  <= 3'h0;
            cnt   <= 32'h0;
            if (cmd_op == OP_HWSTORE)
              state <= ST_REQ;
            else
            begin
              state <= (cmd_op == OP_STORE || cmd_op == OP_RECALL) ? ST_SEQ : ST_ACCESS;
              start <= 1'b1;
            end
          end
        ST_ACCESS:
          if (done)
            state <= ST_IDLE;
        ST_SEQ:
          // six reads back to back, nothing else in between
          if (done)
          begin
            if (step == `NV_SEQ_LAST)
            begin
              state <= ST_COPY;  // sixth read launches the copy
              cnt   <= 32'h0;
            end
            else
            begin
              step  <= step + 3'h1;  // next address in order
              start <= 1'b1;
            end
          end
        ST_COPY:
          // keep off the port until the copy time is surely over
          if (cnt + 32'h1 >= (op == OP_RECALL ? RECALL_CYC : COPY_CYC))
            state <= ST_DRAIN;
        ST_REQ:
          // hold low past the least width, then give the device its delay
          if (cnt + 32'h1 >= REQ_CYC + DELAY_CYC)
            state <= ST_DRAIN;
        ST_DRAIN:
          if (line_s)
            state <= ST_IDLE;  // port is off until the line is high again
        default:
          state <= ST_IDLE;
      endcase
    end

  // busy line request: open drain, low level driven only while requesting
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      store_busy_line_n_out <= 1'b0;
      store_busy_line_n_oe  <= 1'b0;
    end
    else
    begin
      store_busy_line_n_out <= 1'b0;
      store_busy_line_n_oe  <= (state == ST_IDLE) ? (cmd_valid && cmd_ready && cmd_op == OP_HWSTORE)
                             : (state == ST_REQ) && (cnt + 32'h1 < REQ_CYC);
    end

  // user handshake and status
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      nv_busy   <= 1'b0;
    end
    else
    begin
      cmd_ready <= next_ready;
      rsp_valid <= (state == ST_ACCESS && done) || (state == ST_DRAIN && line_s);
      nv_busy   <= (state == ST_COPY) || (state == ST_REQ) || (state == ST_DRAIN) || !line_s;
    end

  // assertion helpers: cycles the line has been held low by us
  logic [31:0] hold_cnt;
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      hold_cnt <= 32'h0;
    else
      hold_cnt <= store_busy_line_n_oe ? hold_cnt + 32'h1 : 32'h0;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_prefix_addr: assert property (
    $fell(chip_en_n) && state == ST_SEQ && step < 3'h3 |-> address_pins == seq_addr(step, 1'b0))
    else $error("unlock prefix address wrong");
  chk_store_tail: assert property (
    $fell(chip_en_n) && state == ST_SEQ && step >= 3'h3 && op == OP_STORE
    |-> address_pins == seq_addr(step, 1'b0))
    else $error("store tail address wrong");
  chk_recall_last: assert property (
    $fell(chip_en_n) && state == ST_SEQ && step == `NV_SEQ_LAST && op == OP_RECALL
    |-> address_pins == `NV_SEQ_RECALL)
    else $error("recall sixth address wrong");
  chk_steps_are_reads: assert property (
    state == ST_SEQ && !chip_en_n |-> write_en_n && !data_pins_oe)
    else $error("write during unlock sequence");
  chk_step_ce_edge: assert property (
    state == ST_SEQ && $rose(chip_en_n) |=> chip_en_n)
    else $error("chip enable not released between steps");
  // hold_cnt has counted every cycle the request stood, including the last one
  chk_req_width: assert property (
    $fell(store_busy_line_n_oe) |-> hold_cnt >= REQ_CYC)
    else $error("busy request pulse too short");
  chk_ready_line_high: assert property (
    $rose(cmd_ready) |-> $past(line_s) && line_s == $past(line_s))
    else $error("ready while busy line low");
  chk_seq_no_intrude: assert property (
    state == ST_SEQ |-> !cmd_ready ##1 (state == ST_SEQ || state == ST_COPY))
    else $error("sequence interrupted");
  chk_copy_quiet: assert property (
    state == ST_COPY |-> chip_en_n && !start)
    else $error("port touched during copy");

  cov_sw_store: cover property (state == ST_COPY && op == OP_STORE ##1 state == ST_DRAIN);
  cov_sw_recall: cover property (state == ST_COPY && op == OP_RECALL ##1 state == ST_DRAIN);
  cov_hw_store: cover property ($fell(store_busy_line_n_oe) && state == ST_REQ);
  cov_write: cover property (state == ST_ACCESS && op == OP_WRITE && done);

endmodule // nv_host_ctrl

// ===== hdl/nv_host_cfg.svh
// Functional notes
// - unlock opens with reads of 0e38, 31c7, 03e0 in that order
// - then reads 3c1f, 303f; sixth read 0fc0 starts a store
// - same five reads then 0c63 start a recall
// - every unlock step is a read, never a write
// - busy line held low past minimum width requests a store after delay
// - any other access between steps aborts; six reads back to back
// - write enable high while chip enable low; chip enable clocks steps
`ifndef NV_HOST_CFG_SVH
`define NV_HOST_CFG_SVH

`define NV_CLK_NS          4
`define NV_CEIL_CYC(ns)    (((ns) + `NV_CLK_NS - 1) / `NV_CLK_NS)

// pin timing in ns
`define NV_T_ACCESS_NS     45
`define NV_T_RECOV_NS      10
`define NV_T_COPY_NS       10000000
`define NV_T_RECALL_NS     20000
`define NV_T_REQ_MIN_NS    100
`define NV_T_REQ_DELAY_NS  100

// unlock addresses
`define NV_SEQ_A0          15'h0e38
`define NV_SEQ_A1          15'h31c7
`define NV_SEQ_A2          15'h03e0
`define NV_SEQ_A3          15'h3c1f
`define NV_SEQ_A4          15'h303f
`define NV_SEQ_STORE       15'h0fc0
`define NV_SEQ_RECALL      15'h0c63
`define NV_SEQ_LAST        3'h5

`endif

// ===== hdl/nv_host_pkg.sv
`include "nv_host_cfg.svh"

package nv_host_pkg;

  typedef enum logic [2:0] {
    OP_READ    = 3'h0,
    OP_WRITE   = 3'h1,
    OP_STORE   = 3'h2,
    OP_RECALL  = 3'h3,
    OP_HWSTORE = 3'h4
  } op_t;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_ACCESS = 6'b000010,
    ST_SEQ    = 6'b000100,
    ST_COPY   = 6'b001000,
    ST_REQ    = 6'b010000,
    ST_DRAIN  = 6'b100000
  } state_t;

  // address of one unlock step; the sixth picks store or recall
  function automatic logic [14:0] seq_addr(input logic [2:0] step, input logic recall);
    case (step)
      3'h0:    seq_addr = `NV_SEQ_A0;
      3'h1:    seq_addr = `NV_SEQ_A1;
      3'h2:    seq_addr = `NV_SEQ_A2;
      3'h3:    seq_addr = `NV_SEQ_A3;
      3'h4:    seq_addr = `NV_SEQ_A4;
      default: seq_addr = recall ? `NV_SEQ_RECALL : `NV_SEQ_STORE;
    endcase
  endfunction

endpackage

// ===== hdl/nv_pin_cycle.sv
`timescale 1ns/10ps
`include "nv_host_cfg.svh"

// one asynchronous sram cycle: address setup, chip enable low, recovery high
module nv_pin_cycle #(
  parameter int unsigned ACC_CYC = `NV_CEIL_CYC(`NV_T_ACCESS_NS),
  parameter int unsigned REC_CYC = `NV_CEIL_CYC(`NV_T_RECOV_NS)
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic        quiet,
  input  wire logic [14:0] addr,
  input  wire logic [7:0]  wdata,
  output logic             done,
  output logic [7:0]       rdata,
  output logic [14:0]      address_pins,
  input  wire logic [7:0]  data_pins_in,
  output logic [7:0]       data_pins_out,
  output logic             data_pins_oe,
  output logic             chip_en_n,
  output logic             write_en_n,
  output logic             out_en_n
);

  logic [1:0]  phase;  // 0 idle, 1 setup, 2 active, 3 recovery
  logic [15:0] cnt;
  logic [7:0]  din_a;
  logic [7:0]  din_b;

  // data pins pass two flops; the access window is stretched by two to match
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      din_a <= 8'h00;
      din_b <= 8'h00;
    end
    else
    begin
      din_a <= data_pins_in;
      din_b <= din_a;
    end

  // cycle sequencer and pin drive
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      phase         <= 2'h0;
      cnt           <= 16'h0000;
      done          <= 1'b0;
      rdata         <= 8'h00;
      address_pins  <= 15'h0000;
      data_pins_out <= 8'h00;
      data_pins_oe  <= 1'b0;
      chip_en_n     <= 1'b1;
      write_en_n    <= 1'b1;
      out_en_n      <= 1'b1;
    end
    else
    begin
      done <= 1'b0;
      cnt  <= cnt + 16'h0001;
      case (phase)
        2'h0:
          if (start)
          begin
            phase         <= 2'h1;
            address_pins  <= addr;
            data_pins_out <= wdata;
            data_pins_oe  <= is_write;
          end
        2'h1:
        begin
          phase      <= 2'h2;
          cnt        <= 16'h0000;
          chip_en_n  <= 1'b0;
          write_en_n <= !is_write;  // high on every unlock step
          out_en_n   <= is_write || quiet;  // steps run with output off
        end
        2'h2:
          if (cnt == 16'(ACC_CYC + 1))
          begin
            phase      <= 2'h3;
            cnt        <= 16'h0000;
            rdata      <= din_b;
            chip_en_n  <= 1'b1;  // rising edge ends the step
            write_en_n <= 1'b1;
            out_en_n   <= 1'b1;
          end
        default:
          if (cnt + 16'h0001 >= 16'(REC_CYC))
          begin
            phase        <= 2'h0;
            data_pins_oe <= 1'b0;
            done         <= 1'b1;
          end
      endcase
    end

endmodule // nv_pin_cycle

// ===== bench/nv_store_model.sv
`timescale 1ns/10ps

// behavioural nvsram: array, shadow copy, unlock detector and busy line
module nv_store_model #(
  parameter int unsigned STORE_CYC  = 40,
  parameter int unsigned RECALL_CYC = 10,
  parameter int unsigned MIN_CYC    = 20,
  parameter int unsigned DELAY_CYC  = 20
) (
  input  wire logic        core_clk,
  input  wire logic        cap_ok,
  input  wire logic [14:0] address_pins,
  input  wire logic [7:0]  bus,
  output logic [7:0]       q,
  input  wire logic        chip_en_n,
  input  wire logic        write_en_n,
  input  wire logic        out_en_n,
  input  wire logic        line_n,
  output logic             drive
);
  localparam logic [14:0] SEQ [5] = '{15'h0e38, 15'h31c7, 15'h03e0, 15'h3c1f, 15'h303f};
  logic [7:0]  sram [32768];
  logic [7:0]  shadow [32768];
  logic [7:0]  last = 8'h00;
  logic [2:0]  step = 3'h0;
  logic [31:0] tmr = 0, lowcnt = 0, dly = 0;
  logic        ce_q = 1'b1, hold = 1'b0, wrote = 1'b0, req = 1'b0;
  logic [17:0] ctl_q = 18'h00000;
  wire         dis  = (tmr != 0) || hold;  // port off during copies
  wire         live = !chip_en_n && !out_en_n && write_en_n && !dis;
  wire         moved = ({address_pins, chip_en_n, write_en_n, out_en_n} != ctl_q);  // any address or control pin change

  initial
  begin
    drive = 1'b0;
    foreach (sram[i]) sram[i] = 8'h00;
    foreach (shadow[i]) shadow[i] = 8'h00;
  end

  // a released bus shows the inverse of the last value, never a stale copy
  assign q = live ? sram[address_pins] : ~last;

  // one clocked process keeps the whole device state
  always @(posedge core_clk)
  begin
    ce_q <= chip_en_n;
    ctl_q <= {address_pins, chip_en_n, write_en_n, out_en_n};
    if (live) last <= sram[address_pins];
    if (!chip_en_n && !write_en_n && !dis && !req)  // write during a request is dropped
    begin
      sram[address_pins] <= bus;
      wrote <= 1'b1;
    end
    if (!line_n && !drive && !req && !hold && tmr == 0) lowcnt <= lowcnt + 1;
    else lowcnt <= 0;
    if (ce_q && !chip_en_n && !dis)
    begin
      if (!write_en_n) step <= 3'h0;
      else if (step == 3'h5 && address_pins == 15'h0fc0)
      begin
        step <= 3'h0;
        drive <= cap_ok;
        tmr <= cap_ok ? STORE_CYC : 0;
      end
      else if (step == 3'h5 && address_pins == 15'h0c63)
      begin
        step <= 3'h0;
        sram <= '{default: 8'h00};  // clear first, load later
        tmr <= RECALL_CYC;
      end
      else if (step < 3'h5 && address_pins == SEQ[step]) step <= step + 3'h1;
      else step <= (address_pins == SEQ[0]) ? 3'h1 : 3'h0;
    end
    if (hold && line_n) hold <= 1'b0;
    // request held past the minimum width starts a store after the delay, if written since the last store and cap_ok
    if (req)
    begin
      if (dly != 0 && !moved) dly <= dly - 1;  // port keeps serving reads, a pin change cuts it short
      else
      begin
        req <= 1'b0;
        if (wrote && cap_ok)
        begin
          drive <= 1'b1;
          tmr <= STORE_CYC;
        end
        else hold <= 1'b1;
      end
    end
    else if (lowcnt == MIN_CYC)
    begin
      req <= 1'b1;
      dly <= DELAY_CYC;
    end
    if (tmr != 0)
    begin
      tmr <= tmr - 1;
      if (tmr == 1)
      begin
        if (drive)
        begin
          shadow <= sram;
          hold <= 1'b1;
          wrote <= 1'b0;
        end
        else sram <= shadow;  // shadow untouched
        drive <= 1'b0;
      end
    end
  end
endmodule // nv_store_model

// ===== bench/nv_store_recall_control_bench.sv
`timescale 1ns/10ps

// host controller against the device model
module nv_store_recall_control_bench;
  import nv_host_pkg::*;
  typedef struct packed {op_t op; logic [14:0] addr; logic [7:0] wdata; logic [7:0] rdata;} row_t;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cap_ok = 1'b1;
  logic        cmd_valid = 1'b0;
  op_t         cmd_op = OP_READ;
  logic [14:0] cmd_addr = 15'h0000;
  logic [7:0]  cmd_wdata = 8'h00;
  logic [7:0]  rd;
  int          low, bsy, n_fail = 0, n_checks = 0;
  logic        cmd_ready, rsp_valid, nv_busy, data_pins_oe, chip_en_n, write_en_n, out_en_n;
  logic        busy_out, busy_oe, dev_drive;
  logic [7:0]  rsp_rdata, data_pins_out, dev_q;
  logic [14:0] address_pins;
  wire         line_n  = !((busy_oe && !busy_out) || dev_drive);  // weak pull-up
  wire  [7:0]  data_in = data_pins_oe ? data_pins_out : dev_q;
  row_t        rows [6] = '{'{OP_WRITE, 15'h0001, 8'ha5, 8'h00}, '{OP_WRITE, 15'h7fff, 8'h3c, 8'h00},
                            '{OP_WRITE, 15'h0e38, 8'h5a, 8'h00}, '{OP_READ, 15'h0001, 8'h00, 8'ha5},
                            '{OP_READ, 15'h7fff, 8'h00, 8'h3c}, '{OP_READ, 15'h0e38, 8'h00, 8'h5a}};

  always #2 core_clk = ~core_clk;

  nv_host_ctrl #(.COPY_CYC(50), .RECALL_CYC(20)) dut_u (
    .core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .nv_busy(nv_busy), .address_pins(address_pins), .data_pins_in(data_in), .data_pins_out(data_pins_out),
    .data_pins_oe(data_pins_oe), .chip_en_n(chip_en_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
    .store_busy_line_n_in(line_n), .store_busy_line_n_out(busy_out), .store_busy_line_n_oe(busy_oe));

  nv_store_model dev_u (
    .core_clk(core_clk), .cap_ok(cap_ok), .address_pins(address_pins), .bus(data_in), .q(dev_q),
    .chip_en_n(chip_en_n), .write_en_n(write_en_n), .out_en_n(out_en_n), .line_n(line_n), .drive(dev_drive));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  // one command, held until taken; counts cycles the device alone pulls the line low
  task automatic cmd(input op_t op, input logic [14:0] a, input logic [7:0] d);
    int k;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    low = 0;
    bsy = 0;
    for (k = 0; k < 200 && cmd_ready !== 1'b1; k++) tick();
    if (k == 200)
    begin
      n_fail++;
      end_of_test();
    end
    tick();
    cmd_valid = 1'b0;
    for (k = 0; k < 3000 && rsp_valid !== 1'b1; k++)
    begin
      tick();
      if (line_n === 1'b0 && busy_oe !== 1'b1) low++;  // our own request pulse is not counted
      if (nv_busy === 1'b1) bsy++;
    end
    if (k == 3000)
    begin
      n_fail++;
      end_of_test();
    end
    rd = rsp_rdata;
  endtask

  task automatic read_check(input string what, input logic [14:0] a, input logic [7:0] e);
    cmd(OP_READ, a, 8'h00);
    check(what, rd, e);
  endtask

  // ordinary rows first, then store, recall and busy-line cases
  initial
  begin
    repeat (19) @(posedge core_clk);
    #1;
    check("strobe in reset", {7'h00, chip_en_n}, 8'h01);
    check("ready in reset", {7'h00, cmd_ready}, 8'h00);
    check("line oe in reset", {7'h00, busy_oe}, 8'h00);
    tick();
    rstn = 1'b1;
    $display("test reset done");
    foreach (rows[i])
    begin
      cmd(rows[i].op, rows[i].addr, rows[i].wdata);
      if (rows[i].op == OP_READ) check("row read", rd, rows[i].rdata);
      check("row not busy", {7'h00, bsy > 0}, 8'h00);
    end
    $display("test rows done");
    cmd(OP_STORE, 15'h0000, 8'h00);
    check("sw store busy", {7'h00, low > 0}, 8'h01);
    check("sw store nv busy", {7'h00, bsy > 0}, 8'h01);
    cmd(OP_WRITE, 15'h0001, 8'h00);
    cmd(OP_WRITE, 15'h0002, 8'hee);
    cmd(OP_RECALL, 15'h0000, 8'h00);
    read_check("recall stored", 15'h0001, 8'ha5);
    read_check("recall cleared", 15'h0002, 8'h00);
    cmd(OP_RECALL, 15'h0000, 8'h00);
    read_check("second recall", 15'h7fff, 8'h3c);
    $display("test software store recall done");
    cmd(OP_WRITE, 15'h0001, 8'h77);
    cmd(OP_HWSTORE, 15'h0000, 8'h00);
    check("hw store busy", {7'h00, low > 0}, 8'h01);
    cmd(OP_WRITE, 15'h0001, 8'h00);
    cmd(OP_RECALL, 15'h0000, 8'h00);
    read_check("hw store kept", 15'h0001, 8'h77);
    $display("test busy line store done");
    cmd(OP_STORE, 15'h0000, 8'h00);
    cmd(OP_HWSTORE, 15'h0000, 8'h00);
    check("hw store ignored", {7'h00, low > 0}, 8'h00);
    cmd(OP_WRITE, 15'h0001, 8'h55);
    cmd(OP_RECALL, 15'h0000, 8'h00);
    read_check("no write no store", 15'h0001, 8'h77);
    $display("test ignored request done");
    // weak holdup capacitor: the software store must not run
    cap_ok = 1'b0;
    cmd(OP_WRITE, 15'h0001, 8'h99);
    cmd(OP_STORE, 15'h0000, 8'h00);
    check("low cap no busy", {7'h00, low > 0}, 8'h00);
    cap_ok = 1'b1;
    cmd(OP_RECALL, 15'h0000, 8'h00);
    read_check("low cap kept", 15'h0001, 8'h77);
    $display("test low capacitor done");
    end_of_test();
  end
endmodule // nv_store_recall_control_bench
